// [design/sgc_core.sv]
// Chosen here: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module sgc_core
    import sgc_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Drive control side
    input  wire logic        ctrl_tick,
    input  wire logic        run_active,
    input  wire logic        decel_active,
    input  wire logic [15:0] speed_cmd_freq,
    input  wire logic [15:0] motor_freq,
    input  wire logic [15:0] speed_cmd_in,
    input  wire logic [5:0]  floor_index,
    // Weighing inputs
    input  wire logic [15:0] load_serial,
    input  wire logic [15:0] load_bipolar,
    input  wire logic [15:0] load_unipolar,
    // Outputs to vector controller
    output logic [1:0]       motor_model,
    output logic [15:0]      async_back_emf,
    output logic [15:0]      async_noload_i,
    output logic [15:0]      async_slip,
    output logic [15:0]      ppr_eff,
    output logic [15:0]      machine_rpm_eff,
    output logic [15:0]      um_per_pulse,
    output logic [15:0]      speed_ref_out,
    output logic [15:0]      kp_out,
    output logic [15:0]      ki_out,
    output logic [1:0]       gain_group,
    output logic [15:0]      comp_torque
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Percent scaling, percent capped at full scale
    function automatic logic [15:0] scale_pct(input logic [15:0] v,
                                              input logic [15:0] pct);
        logic [31:0] prod;
        logic [15:0] p;
        p    = (pct > PCT_FULL) ? PCT_FULL : pct;
        prod = v * p;
        return 16'(prod / 32'(PCT_FULL));
    endfunction

    // Division that treats a zero divisor as one
    function automatic logic [31:0] safe_div(input logic [31:0] n,
                                             input logic [31:0] d);
        return (d == 32'h0) ? n : n / d;
    endfunction

    // ****************************************************************
    // Bus slave
    // ****************************************************************
    logic [15:0] cfg_reg [0:CFG_WORDS-1]; // Register words
    logic        wr_pend_reg;              // Write data phase pending
    logic [4:0]  wr_ix_reg;                // Index of pending write
    logic [15:0] gain_st;                  // Gain status word
    logic        addr_ok;                  // Address phase accepted
    logic [4:0]  a_ix;                     // Address phase index
    logic [15:0] rd_word;                  // Read mux output
    logic [15:0] load_meas_reg;            // Monitored serial load

    assign hreadyout = 1'b1;               // Zero wait states
    assign hresp     = 1'b0;               // Always OKAY
    assign addr_ok   = hsel & htrans[1] & hready;
    assign a_ix      = haddr[6:2];
    assign gain_st   = {14'h0, gain_group};

    // Write data phase tracking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_ix_reg   <= 5'h00;
        end else begin
            wr_pend_reg <= addr_ok & hwrite & (haddr[31:7] == 25'h0);
            wr_ix_reg   <= a_ix;
        end
    end

    // Configuration words, writes land in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < CFG_WORDS; i++) begin
                cfg_reg[i] <= 16'h0000;
            end
            cfg_reg[IX_CTRL]    <= CTRL_RST;
            cfg_reg[IX_SPD_PCT] <= PCT_FULL;
        end else if (wr_pend_reg && wr_ix_reg <= IX_LAST_RW) begin
            cfg_reg[wr_ix_reg] <= hwdata[15:0];
        end
    end

    // Read mux, forwarding a write still in its data phase
    always_comb begin
        rd_word = 16'h0000;
        if (haddr[31:7] != 25'h0) begin
            rd_word = 16'h0000;            // Unmapped reads zero
        end else if (wr_pend_reg && wr_ix_reg == a_ix && a_ix <= IX_LAST_RW) begin
            rd_word = hwdata[15:0];
        end else begin
            case (a_ix)
                IX_ST_PPR:  rd_word = ppr_eff;
                IX_ST_RPM:  rd_word = machine_rpm_eff;
                IX_ST_LOAD: rd_word = load_meas_reg;
                IX_ST_GAIN: rd_word = gain_st;
                IX_ST_TORQ: rd_word = comp_torque;
                IX_ST_UMPP: rd_word = um_per_pulse;
                default:    rd_word = (a_ix <= IX_LAST_RW) ? cfg_reg[a_ix] : 16'h0000;
            endcase
        end
    end

    // Read data captured at the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (addr_ok && !hwrite) begin
            hrdata <= {16'h0, rd_word};
        end
    end

    // ****************************************************************
    // Motor model and hoistway scaling
    // ****************************************************************
    logic [15:0] ctrl_w;                   // Control word
    logic [1:0]  mtype;                    // Raw motor type field
    logic        is_async;                 // Async machine selected
    logic        int_puls;                 // Internal pulse source
    logic [31:0] ppr_calc;                 // Count over divider
    logic [31:0] umpp_calc;                // Travel per pulse

    assign ctrl_w   = cfg_reg[IX_CTRL];
    assign mtype    = ctrl_w[CF_MTYPE_LO +: 2];
    assign is_async = (mtype == MT_ASYNC);
    assign int_puls = ctrl_w[CF_INT_PULS];
    assign ppr_calc = safe_div(32'(cfg_reg[IX_ENC_CNT]), 32'(cfg_reg[IX_ENC_DIV]));
    assign umpp_calc = safe_div(32'(cfg_reg[IX_LIFT_SPD]) * UM_PER_MIN,
                                32'(machine_rpm_eff) * 32'(ppr_eff));

    // Model selection and async parameter gating
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            motor_model    <= MT_SYNC_OUTER;
            async_back_emf <= 16'h0000;
            async_noload_i <= 16'h0000;
            async_slip     <= 16'h0000;
        end else begin
            case (mtype)
                MT_ASYNC:      motor_model <= MT_ASYNC;
                MT_SYNC_INNER: motor_model <= MT_SYNC_INNER;
                default:       motor_model <= MT_SYNC_OUTER;
            endcase
            async_back_emf <= is_async ? cfg_reg[IX_BACK_EMF] : 16'h0000;
            async_noload_i <= is_async ? cfg_reg[IX_NOLOAD_I] : 16'h0000;
            async_slip     <= is_async ? cfg_reg[IX_SLIP] : 16'h0000;
        end
    end

    // Effective pulses and machine speed, then distance scale
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ppr_eff         <= 16'h0000;
            machine_rpm_eff <= 16'h0000;
            um_per_pulse    <= 16'h0000;
        end else begin
            if (int_puls) begin
                ppr_eff         <= ppr_calc[15:0];
                machine_rpm_eff <= cfg_reg[IX_MOT_RPM];
            end else begin
                ppr_eff         <= cfg_reg[IX_PPR];
                machine_rpm_eff <= cfg_reg[IX_MACH_RPM];
            end
            um_per_pulse <= umpp_calc[15:0];
        end
    end

    // Commanded speed scaled by the speed ratio
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            speed_ref_out <= 16'h0000;
        end else begin
            speed_ref_out <= scale_pct(speed_cmd_in, cfg_reg[IX_SPD_PCT]);
        end
    end

    // ****************************************************************
    // Gain scheduling
    // ****************************************************************
    sgc_gain_t   gs_reg;                   // Active group
    sgc_gain_t   gs_next;                  // Group for next tick
    logic        multi_en;                 // Scheduling enabled
    logic [15:0] decel_thr;                // Deceleration threshold

    assign multi_en  = ctrl_w[CF_MULTI];
    assign decel_thr = cfg_reg[IX_FREQ_DEC];

    // Next group selection
    always_comb begin
        gs_next = gs_reg;
        if (!multi_en) begin
            gs_next = GS_BASE;
        end else if (!run_active) begin
            gs_next = GS_START;
        end else if (decel_active || gs_reg == GS_DECEL) begin
            if (gs_reg == GS_DECEL) begin
                gs_next = GS_DECEL;
            end else if (decel_thr != 16'h0000 && motor_freq < decel_thr) begin
                gs_next = GS_DECEL;
            end else begin
                gs_next = gs_reg;
            end
        end else if (speed_cmd_freq < cfg_reg[IX_FREQ_ONE] && gs_reg == GS_START) begin
            gs_next = GS_START;
        end else if (motor_freq < cfg_reg[IX_FREQ_TWO]) begin
            gs_next = GS_MID;
        end else begin
            gs_next = GS_BASE;
        end
    end

    // Group and gain pair change together on the tick
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gs_reg <= GS_BASE;
            kp_out <= 16'h0000;
            ki_out <= 16'h0000;
        end else if (ctrl_tick) begin
            gs_reg <= gs_next;
            case (gs_next)
                GS_START: begin
                    kp_out <= cfg_reg[IX_START_P];
                    ki_out <= cfg_reg[IX_START_I];
                end
                GS_MID: begin
                    kp_out <= cfg_reg[IX_MID_P];
                    ki_out <= cfg_reg[IX_MID_I];
                end
                GS_DECEL: begin
                    kp_out <= cfg_reg[IX_DEC_P];
                    ki_out <= cfg_reg[IX_DEC_I];
                end
                default: begin
                    kp_out <= cfg_reg[IX_BASE_P];
                    ki_out <= cfg_reg[IX_BASE_I];
                end
            endcase
        end
    end

    assign gain_group = gs_reg;

    // ****************************************************************
    // Load compensation
    // ****************************************************************
    logic [15:0] load_sel;                 // Selected load magnitude
    logic        load_neg;                 // Bipolar source negative
    logic [15:0] floor_term;               // Per-floor correction
    logic [15:0] comp_mag;                 // Scaled load torque
    logic [15:0] max_comp;                 // Percent of rated torque

    assign max_comp   = cfg_reg[IX_MAX_COMP];
    assign floor_term = 16'(cfg_reg[IX_FLOOR_ADJ] * {10'h000, floor_index});

    // Weigher measurement, zero while disabled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            load_meas_reg <= 16'h0000;
        end else begin
            load_meas_reg <= ctrl_w[CF_WEIGH] ? load_serial : 16'h0000;
        end
    end

    // Source selection, capped at full load
    always_comb begin
        load_neg = 1'b0;
        case (ctrl_w[CF_LSRC_LO +: 2])
            LS_SERIAL:   load_sel = load_meas_reg;
            LS_BIPOLAR: begin
                load_neg = load_bipolar[15];
                load_sel = load_neg ? 16'(-load_bipolar) : load_bipolar;
            end
            LS_UNIPOLAR: load_sel = load_unipolar;
            default:     load_sel = 16'h0000;
        endcase
        if (load_sel > LOAD_FULL) begin
            load_sel = LOAD_FULL;
        end
    end

    // Full load maps to max_comp percent, in hundredths of a percent
    assign comp_mag = scale_pct(load_sel, max_comp) ;

    // Signed torque output with floor correction
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            comp_torque <= 16'h0000;
        end else if (!ctrl_w[CF_TCOMP]) begin
            comp_torque <= 16'h0000;
        end else begin
            comp_torque <= (load_neg ? 16'(-comp_mag) : comp_mag)
                           + floor_term;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence tick_s;
        ctrl_tick;
    endsequence

    async_gate_a: assert property (!is_async |=> async_slip == 16'h0000
                                   && async_back_emf == 16'h0000)
        else $error("async parameters leak for synchronous machine");

    int_ppr_a: assert property (int_puls && $stable(ppr_calc)
                                |=> ppr_eff == $past(ppr_calc[15:0]))
        else $error("internal pulses per rev mismatch");

    speed_scale_a: assert property (cfg_reg[IX_SPD_PCT] == PCT_FULL
                                    && hresetn && $stable(speed_cmd_in)
                                    |=> speed_ref_out == $past(speed_cmd_in))
        else $error("full ratio does not give rated speed");

    base_gain_a: assert property (tick_s ##0 !multi_en
                                  |=> kp_out == $past(cfg_reg[IX_BASE_P])
                                      && gain_group == GS_BASE)
        else $error("base gains not applied with scheduling off");

    idle_start_a: assert property (tick_s ##0 multi_en && !run_active
                                   |=> gain_group == GS_START)
        else $error("start group not armed at standstill");

    decel_keep_a: assert property (tick_s ##0 multi_en && run_active && decel_active
                                   && decel_thr == 16'h0000 && gs_reg != GS_DECEL
                                   |=> $stable(gain_group))
        else $error("zero threshold switched gain group");

    gain_hold_a: assert property (!ctrl_tick |=> $stable(kp_out) && $stable(ki_out))
        else $error("gain pair changed off a control tick");

    comp_off_a: assert property (!ctrl_w[CF_TCOMP] |=> comp_torque == 16'h0000)
        else $error("compensation active while disabled");

    weigh_off_a: assert property (!ctrl_w[CF_WEIGH] ##1 !ctrl_w[CF_WEIGH]
                                  |-> load_meas_reg == 16'h0000)
        else $error("load measurement shown while weigher off");

endmodule
`default_nettype wire

// [design/sgc_pkg.sv]
// Notes on behaviour
// - Motor type 0 outer sync, 1 async, 2 inner
// - Async-only parameters ignored for synchronous machines
// - Internal source: pulses equal count over divider
// - Distance scale from lift speed, machine rpm and pulses
// - Commanded speed scaled by speed ratio percent
// - Scheduling off: base gain pair always
// - Scheduling on: choose among four gain groups
// - Below first threshold at start: start group
// - Between thresholds mid group, above base pair
// - Decelerating below third threshold: deceleration group
// - Third threshold zero keeps previous group
// - Weigher enable gates readable load measurement
// - Load source 0 serial, 1 bipolar, 2 unipolar
// - Full load gives maximum compensation percent
// - Compensation enable: load times scale, else none
// - Per-floor adjustment added to compensation torque
package sgc_pkg;

    // ****************************************************************
    // Register word indices (byte address is index times four)
    // ****************************************************************
    localparam int unsigned CFG_WORDS   = 32;  // Decoded word slots
    localparam logic [4:0] IX_CTRL      = 5'h00; // Mode and enable bits
    localparam logic [4:0] IX_MOT_RPM   = 5'h01; // motor_rated_rpm
    localparam logic [4:0] IX_BACK_EMF  = 5'h02; // motor_back_emf
    localparam logic [4:0] IX_NOLOAD_I  = 5'h03; // no_load_current
    localparam logic [4:0] IX_SLIP      = 5'h04; // motor_rated_slip
    localparam logic [4:0] IX_LIFT_SPD  = 5'h05; // lift_rated_speed, mm/s
    localparam logic [4:0] IX_MACH_RPM  = 5'h06; // machine_rated_rpm
    localparam logic [4:0] IX_PPR       = 5'h07; // pulses_per_rev
    localparam logic [4:0] IX_ENC_CNT   = 5'h08; // encoder_pulse_count
    localparam logic [4:0] IX_ENC_DIV   = 5'h09; // encoder_div_ratio
    localparam logic [4:0] IX_SPD_PCT   = 5'h0a; // speed_ratio_pct
    localparam logic [4:0] IX_BASE_P    = 5'h0b; // base_prop_gain
    localparam logic [4:0] IX_BASE_I    = 5'h0c; // base_integ_gain
    localparam logic [4:0] IX_FREQ_ONE  = 5'h0d; // gain_switch_freq_one
    localparam logic [4:0] IX_FREQ_TWO  = 5'h0e; // gain_switch_freq_two
    localparam logic [4:0] IX_FREQ_DEC  = 5'h0f; // decel_switch_freq
    localparam logic [4:0] IX_START_P   = 5'h10; // start_group_prop_gain
    localparam logic [4:0] IX_START_I   = 5'h11; // start_group_integ_gain
    localparam logic [4:0] IX_MID_P     = 5'h12; // mid_group_prop_gain
    localparam logic [4:0] IX_MID_I     = 5'h13; // mid_group_integ_gain
    localparam logic [4:0] IX_DEC_P     = 5'h14; // decel_group_prop_gain
    localparam logic [4:0] IX_DEC_I     = 5'h15; // decel_group_integ_gain
    localparam logic [4:0] IX_MAX_COMP  = 5'h16; // max_comp_torque_pct
    localparam logic [4:0] IX_FLOOR_ADJ = 5'h17; // floor_load_adjust
    localparam logic [4:0] IX_LAST_RW   = 5'h17; // Highest writable slot
    localparam logic [4:0] IX_ST_PPR    = 5'h18; // Effective pulses per rev
    localparam logic [4:0] IX_ST_RPM    = 5'h19; // Effective machine rpm
    localparam logic [4:0] IX_ST_LOAD   = 5'h1a; // load_measure_value
    localparam logic [4:0] IX_ST_GAIN   = 5'h1b; // Active gain group
    localparam logic [4:0] IX_ST_TORQ   = 5'h1c; // Compensation torque
    localparam logic [4:0] IX_ST_UMPP   = 5'h1d; // Travel per pulse, um

    // ****************************************************************
    // Control word fields
    // ****************************************************************
    localparam int unsigned CF_MTYPE_LO = 0;  // motor_type_sel, 2 bits
    localparam int unsigned CF_MULTI    = 2;  // multi_gain_enable
    localparam int unsigned CF_WEIGH    = 3;  // weigher_enable
    localparam int unsigned CF_TCOMP    = 4;  // torque_comp_enable
    localparam int unsigned CF_LSRC_LO  = 5;  // load_source_sel, 2 bits
    localparam int unsigned CF_INT_PULS = 7;  // Internal pulse source

    // ****************************************************************
    // Reset values and scaling
    // ****************************************************************
    localparam logic [15:0] CTRL_RST    = 16'h0080; // Internal pulses
    localparam logic [15:0] PCT_FULL    = 16'h0064; // 100 percent
    localparam logic [15:0] LOAD_FULL   = 16'h2710; // Full load reading
    localparam logic [31:0] UM_PER_MIN  = 32'h0000ea60; // mm/s to um/min

    // ****************************************************************
    // Enumerations
    // ****************************************************************
    typedef enum logic [1:0] {
        MT_SYNC_OUTER = 2'b00,
        MT_ASYNC      = 2'b01,
        MT_SYNC_INNER = 2'b10
    } sgc_motor_t;

    typedef enum logic [1:0] {
        LS_SERIAL   = 2'b00,
        LS_BIPOLAR  = 2'b01,
        LS_UNIPOLAR = 2'b10
    } sgc_lsrc_t;

    typedef enum logic [1:0] {
        GS_BASE  = 2'b00,
        GS_START = 2'b01,
        GS_MID   = 2'b10,
        GS_DECEL = 2'b11
    } sgc_gain_t;

endpackage

// [bench/sgc_drive_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Far side: control tick source and run profile of the drive
module sgc_drive_model (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    output logic             ctrl_tick,
    output logic             run_active,
    output logic             decel_active,
    output logic [15:0]      speed_cmd_freq,
    output logic [15:0]      motor_freq
);
    logic [1:0] cnt; // Control period divider
    // Free running divider, cleared by reset
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn) cnt <= 2'h0;
        else cnt <= cnt + 2'h1;
    assign ctrl_tick = (cnt == 2'h3); // One-cycle tick every fourth edge
    // Next profile point, changed just after an edge
    task automatic step(input logic r, d, input logic [15:0] cf, mf);
        @(posedge hclk);
        {run_active, decel_active, speed_cmd_freq, motor_freq} <= {r, d, cf, mf};
    endtask
    initial {run_active, decel_active, speed_cmd_freq, motor_freq} = '0;
endmodule
`default_nettype wire

// [bench/speed_gain_scheduler_load_comp_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module speed_gain_scheduler_load_comp_tb;
    import sgc_pkg::*;
    logic        hclk, hresetn, hsel = 1'b0, hwrite = 1'b0, hreadyout, ctrl_tick, hresp;
    logic        run_active, decel_active;
    logic [1:0]  htrans = 2'h0, motor_model;
    logic [5:0]  floor_index = 6'h3;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [15:0] speed_cmd_freq, motor_freq, speed_cmd_in = 16'h3e8, async_back_emf, ppr_eff;
    logic [15:0] async_noload_i, async_slip, load_bipolar = 16'h2710;
    logic [15:0] machine_rpm_eff, um_per_pulse, speed_ref_out, kp_out, ki_out, comp_torque;
    int          n_fail = 0, n_tests = 0;
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    sgc_core sgc_core_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .ctrl_tick, .run_active,
        .decel_active, .speed_cmd_freq, .motor_freq, .speed_cmd_in, .floor_index,
        .load_serial(16'h7d0), .load_bipolar, .load_unipolar(16'h1388), .motor_model,
        .async_back_emf, .async_noload_i, .async_slip, .ppr_eff, .machine_rpm_eff,
        .um_per_pulse, .speed_ref_out, .kp_out, .ki_out, .gain_group(), .comp_torque);
    sgc_drive_model sgc_drive_model_inst (.hclk, .hresetn, .ctrl_tick, .run_active,
        .decel_active, .speed_cmd_freq, .motor_freq);
    task automatic chk(input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask
    task automatic summarize();
        $display("checks=%0d fails=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Bounded wait for hready at a rising edge
    task automatic rdy();
        int k;
        @(posedge hclk);
        for (k = 0; k < 50 && hreadyout !== 1'b1; k++) @(posedge hclk);
        if (k == 50) begin
            n_fail++;
            summarize();
        end
    endtask
    // Single word transfer; read data is compared with e
    task automatic bus(input logic w, input logic [31:0] a, input logic [15:0] e);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        rdy();
        htrans <= 2'h0;
        hwdata <= {16'h0, e};
        rdy();
        chk(hresp, 32'h0);
        if (!w) chk(hrdata, {16'h0, e});
    endtask
    task automatic settle();
        repeat (12) @(posedge hclk);
        #1;
    endtask
    // Reset values, unmapped read, motor model, pulse and speed scaling
    task automatic t_cfg();
        bus(0, IX_CTRL * 4, 16'h80);
        bus(0, 32'h100, 16'h0);
        bus(1, IX_BACK_EMF * 4, 16'h123);
        bus(1, IX_NOLOAD_I * 4, 16'h45);
        bus(1, IX_SLIP * 4, 16'h67);
        for (int m = 0; m < 3; m++) begin
            bus(1, IX_CTRL * 4, 16'h80 | 16'(m));
            settle();
            chk(motor_model, m);
            chk(async_back_emf, (m == 1) ? 32'h123 : 32'h0);
            chk(async_noload_i, (m == 1) ? 32'h45 : 32'h0);
            chk(async_slip, (m == 1) ? 32'h67 : 32'h0);
        end
        bus(1, IX_ENC_CNT * 4, 16'h3e8);
        bus(1, IX_ENC_DIV * 4, 16'h4);
        bus(1, IX_MOT_RPM * 4, 16'h96);
        bus(1, IX_LIFT_SPD * 4, 16'h3e8);
        bus(1, IX_SPD_PCT * 4, 16'h32);
        settle();
        chk(ppr_eff, 32'hfa);
        chk(machine_rpm_eff, 32'h96);
        chk(um_per_pulse, 32'h640);
        chk(speed_ref_out, 32'h1f4);
        bus(1, IX_LIFT_SPD * 4, 16'h7d0);
        bus(1, IX_MOT_RPM * 4, 16'h12c);
        bus(1, IX_SPD_PCT * 4, 16'h64);
        bus(1, IX_ST_PPR * 4, 16'h1);
        settle();
        chk(um_per_pulse, 32'h640);
        chk(speed_ref_out, 32'h3e8);
        bus(0, IX_ST_PPR * 4, 16'hfa);
        bus(1, IX_CTRL * 4, 16'h0);
        bus(1, IX_PPR * 4, 16'h258);
        bus(1, IX_MACH_RPM * 4, 16'h5a);
        settle();
        chk(ppr_eff, 32'h258);
        chk(machine_rpm_eff, 32'h5a);
    endtask
    // One profile point, then the gain pair in force
    task automatic gstep(input logic r, d, input logic [15:0] cf, mf, p);
        sgc_drive_model_inst.step(r, d, cf, mf);
        settle();
        chk(kp_out, p);
        chk(ki_out, p + 16'h1);
    endtask
    task automatic t_gain();
        for (int i = 0; i < 11; i++) bus(1, (IX_BASE_P + i) * 4, 16'h100 + 16'(i));
        bus(1, IX_FREQ_ONE * 4, 16'h64);
        bus(1, IX_FREQ_TWO * 4, 16'hc8);
        bus(1, IX_FREQ_DEC * 4, 16'h32);
        gstep(1, 0, 16'h96, 16'h96, 16'h100);
        bus(1, IX_CTRL * 4, 16'h84);
        gstep(0, 0, 16'h0, 16'h0, 16'h105);
        gstep(1, 0, 16'h32, 16'h32, 16'h105);
        gstep(1, 0, 16'h96, 16'h96, 16'h107);
        gstep(1, 0, 16'h96, 16'hfa, 16'h100);
        gstep(1, 1, 16'h96, 16'h28, 16'h109);
        bus(0, IX_ST_GAIN * 4, 16'h3);
        gstep(0, 0, 16'h0, 16'h0, 16'h105);
        bus(1, IX_FREQ_DEC * 4, 16'h0);
        gstep(1, 0, 16'h96, 16'hfa, 16'h100);
        gstep(1, 1, 16'h96, 16'h28, 16'h100);
    endtask
    // Each load source, weigher off, compensation off
    task automatic t_load();
        bus(1, IX_MAX_COMP * 4, 16'h3c);
        bus(1, IX_FLOOR_ADJ * 4, 16'h5);
        for (int s = 0; s < 3; s++) begin
            bus(1, IX_CTRL * 4, 16'h18 | 16'(s << 5));
            settle();
            chk(comp_torque, (s == 0) ? 32'h4bf : (s == 1) ? 32'h177f : 32'hbc7);
            if (s == 0) bus(0, IX_ST_LOAD * 4, 16'h7d0);
        end
        load_bipolar <= 16'hb1e0;
        bus(1, IX_CTRL * 4, 16'h38);
        settle();
        chk(comp_torque, 32'he89f);
        bus(1, IX_CTRL * 4, 16'h10);
        settle();
        chk(comp_torque, 32'hf);
        bus(0, IX_ST_LOAD * 4, 16'h0);
        floor_index <= 6'h0;
        bus(1, IX_CTRL * 4, 16'h8);
        settle();
        chk(comp_torque, 32'h0);
    endtask
    initial begin
        hresetn = 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        t_cfg();
        t_gain();
        t_load();
        summarize();
    end
endmodule
`default_nettype wire
